// [pkg/epcvb_pkg.sv]
// constants for the exception pend control and vector base block
// assumes a 32-bit AXI4-Lite register bus and 32 peripheral interrupt lines
package epcvb_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STATE  = 8'h04;
  localparam logic [7:0] OFS_VBASE  = 8'h08;
  localparam logic [7:0] OFS_EVSTAT = 8'h10;
  localparam logic [7:0] OFS_EVMASK = 8'h14;
  localparam int ADDR_W = 8;
  // exception_control_state field positions
  localparam int BIT_NMI_SET   = 31;
  localparam int BIT_DEF_SET   = 28;
  localparam int BIT_DEF_CLR   = 27;
  localparam int BIT_TICK_SET  = 26;
  localparam int BIT_TICK_CLR  = 25;
  localparam int HPN_LSB       = 12;
  localparam int HPN_W         = 6;
  // vector_table_base keeps bits 31:7 only
  localparam logic [31:0] VBASE_MASK  = 32'hFFFF_FF80;
  localparam logic [31:0] VBASE_RESET = 32'h0000_0000;
  // event status bits
  localparam int EV_NMI  = 0;
  localparam int EV_DEF  = 1;
  localparam int EV_TICK = 2;
  localparam int EV_W    = 3;
  // exception numbers
  localparam logic [5:0] EXC_NONE  = 6'h00;
  localparam logic [5:0] EXC_NMI   = 6'h02;
  localparam logic [5:0] EXC_DEF   = 6'h0E;
  localparam logic [5:0] EXC_TICK  = 6'h0F;
  localparam logic [5:0] EXC_PERIPH_BASE = 6'h10;
  localparam int N_PERIPH = 32;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [src/epcvb_prio.sv]
// fixed-order selector of the highest pending enabled exception
// assumes pending inputs are already gated by their enables
`timescale 1ns/10ps
`default_nettype none
module epcvb_prio (
  // pending sources
  input  wire logic [epcvb_pkg::N_PERIPH-1:0] periph_pend,
  input  wire logic                           nmi_pend,
  input  wire logic                           tick_pend,
  input  wire logic                           def_pend,
  // result
  output logic [epcvb_pkg::HPN_W-1:0]         number
);
  // lowest peripheral index wins among peripherals
  function automatic logic [5:0] first_set(input logic [epcvb_pkg::N_PERIPH-1:0] v);
    logic [5:0] idx;
    idx = 6'h00;
    for (int i = epcvb_pkg::N_PERIPH - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 6'(i);
      end
    end
    return idx;
  endfunction

  wire logic       any_periph;
  wire logic [5:0] periph_num;
  assign any_periph = |periph_pend;
  assign periph_num = epcvb_pkg::EXC_PERIPH_BASE + first_set(periph_pend);

  // no priority registers here, so order is fixed: nmi, peripherals, tick, deferred
  assign number = nmi_pend   ? epcvb_pkg::EXC_NMI :
                  any_periph ? periph_num :
                  tick_pend  ? epcvb_pkg::EXC_TICK :
                  def_pend   ? epcvb_pkg::EXC_DEF : epcvb_pkg::EXC_NONE;
endmodule
`default_nettype wire

// [src/epcvb_top.sv]
// exception pend control and vector base registers behind an AXI4-Lite slave
// assumes the core pulses exc_entry on handler entry; one clock, sync reset
// Summary of operation
// - writing one sets nmi pending; zero ignored
// - nmi set bit reads current nmi pending
// - nmi pending goes straight to core
// - nmi handler entry clears nmi pending
// - deferred set bit sets, reads pending state
// - deferred exception pends only by software
// - deferred clear bit write-only, one clears
// - tick set bit sets, reads pending state
// - tick clear bit write-only, one clears
// - report highest pending enabled exception number
// - peripheral zero reports as number sixteen
// - vector base holds table offset from zero
// - table offset keeps bits 31 to 7
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module epcvb_top (
  // clock and reset
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // axi4-lite write address
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [epcvb_pkg::ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic [2:0]                          s_axi_awprot,
  // axi4-lite write data
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  // axi4-lite write response
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  output logic [1:0]                               s_axi_bresp,
  // axi4-lite read address
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  input  wire logic [epcvb_pkg::ADDR_W-1:0]        s_axi_araddr,
  input  wire logic [2:0]                          s_axi_arprot,
  // axi4-lite read data
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  // hardware pending sources
  input  wire logic                                nmi_line,
  input  wire logic                                tick_event,
  input  wire logic                                tick_enable,
  input  wire logic [epcvb_pkg::N_PERIPH-1:0]      periph_pend,
  // handler entry from the core
  input  wire logic                                exc_entry,
  input  wire logic [epcvb_pkg::HPN_W-1:0]         exc_entry_num,
  // to the core
  output logic                                     nmi_pending,
  output logic                                     deferred_pending,
  output logic                                     tick_pending,
  output logic [epcvb_pkg::HPN_W-1:0]              highest_pending_number,
  output logic [31:0]                              vector_base,
  // interrupt
  output logic                                     irq
);
  // write channel state
  logic                          awready_r;
  logic                          wready_r;
  logic                          aw_held_r;
  logic                          w_held_r;
  logic [epcvb_pkg::ADDR_W-1:0]  awaddr_r;
  logic [31:0]                   wdata_r;
  logic [3:0]                    wstrb_r;
  logic                          bvalid_r;
  logic [1:0]                    bresp_r;
  // read channel state
  logic                          arready_r;
  logic                          rvalid_r;
  logic [31:0]                   rdata_r;
  logic [1:0]                    rresp_r;
  // block state
  logic                          nmi_r;
  logic                          nmi_line_r;
  logic                          def_r;
  logic                          tick_r;
  logic [31:0]                   vbase_r;
  logic [epcvb_pkg::EV_W-1:0]    evstat_r;
  logic [epcvb_pkg::EV_W-1:0]    evmask_r;
  logic [epcvb_pkg::HPN_W-1:0]   hpn_r;
  logic                          irq_r;

  // handshakes
  wire logic aw_hs;
  wire logic w_hs;
  wire logic b_hs;
  wire logic ar_hs;
  wire logic r_hs;
  wire logic do_wr;
  assign aw_hs = s_axi_awvalid & awready_r;
  assign w_hs  = s_axi_wvalid & wready_r;
  assign b_hs  = bvalid_r & s_axi_bready;
  assign ar_hs = s_axi_arvalid & arready_r;
  assign r_hs  = rvalid_r & s_axi_rready;
  assign do_wr = aw_held_r & w_held_r & ~bvalid_r;

  // write decode
  wire logic wr_state;
  wire logic wr_vbase;
  wire logic wr_evstat;
  wire logic wr_evmask;
  wire logic wr_hit;
  assign wr_state  = do_wr & (awaddr_r == epcvb_pkg::OFS_STATE);
  assign wr_vbase  = do_wr & (awaddr_r == epcvb_pkg::OFS_VBASE);
  assign wr_evstat = do_wr & (awaddr_r == epcvb_pkg::OFS_EVSTAT);
  assign wr_evmask = do_wr & (awaddr_r == epcvb_pkg::OFS_EVMASK);
  assign wr_hit    = (awaddr_r == epcvb_pkg::OFS_STATE) | (awaddr_r == epcvb_pkg::OFS_VBASE) |
                     (awaddr_r == epcvb_pkg::OFS_EVSTAT) | (awaddr_r == epcvb_pkg::OFS_EVMASK);

  // pend controls all sit in the top byte, so they need byte lane 3
  wire logic st_lane;
  wire logic sw_nmi_set;
  wire logic sw_def_set;
  wire logic sw_def_clr;
  wire logic sw_tick_set;
  wire logic sw_tick_clr;
  assign st_lane     = wr_state & wstrb_r[3];
  assign sw_nmi_set  = st_lane & wdata_r[epcvb_pkg::BIT_NMI_SET];
  assign sw_def_set  = st_lane & wdata_r[epcvb_pkg::BIT_DEF_SET];
  assign sw_def_clr  = st_lane & wdata_r[epcvb_pkg::BIT_DEF_CLR];
  assign sw_tick_set = st_lane & wdata_r[epcvb_pkg::BIT_TICK_SET];
  assign sw_tick_clr = st_lane & wdata_r[epcvb_pkg::BIT_TICK_CLR];

  // hardware sources: nmi on rising line edge, tick on its event pulse
  wire logic hw_nmi;
  wire logic entry_nmi;
  wire logic entry_def;
  wire logic entry_tick;
  assign hw_nmi     = nmi_line & ~nmi_line_r;
  assign entry_nmi  = exc_entry & (exc_entry_num == epcvb_pkg::EXC_NMI);
  assign entry_def  = exc_entry & (exc_entry_num == epcvb_pkg::EXC_DEF);
  assign entry_tick = exc_entry & (exc_entry_num == epcvb_pkg::EXC_TICK);

  // pending next values; a set in the same cycle as a clear wins
  wire logic set_nmi;
  wire logic set_def;
  wire logic set_tick;
  wire logic nmi_nxt;
  wire logic def_nxt;
  wire logic tick_nxt;
  assign set_nmi  = sw_nmi_set | hw_nmi;
  assign set_def  = sw_def_set;
  assign set_tick = sw_tick_set | tick_event;
  assign nmi_nxt  = set_nmi | (nmi_r & ~entry_nmi);
  assign def_nxt  = set_def | (def_r & ~(sw_def_clr | entry_def));
  assign tick_nxt = set_tick | (tick_r & ~(sw_tick_clr | entry_tick));

  // vector base with byte lanes, low seven bits never stored
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  wire logic [31:0] vbase_nxt;
  assign vbase_nxt = lane_merge(vbase_r, wdata_r, wstrb_r) & epcvb_pkg::VBASE_MASK;

  // event status: sticky, write one clears, new event wins
  wire logic [epcvb_pkg::EV_W-1:0] ev_in;
  wire logic [epcvb_pkg::EV_W-1:0] ev_clr;
  wire logic [epcvb_pkg::EV_W-1:0] evstat_nxt;
  wire logic [epcvb_pkg::EV_W-1:0] evmask_nxt;
  assign ev_in      = {set_tick & ~tick_r, set_def & ~def_r, set_nmi & ~nmi_r};
  assign ev_clr     = wr_evstat & wstrb_r[0] ? wdata_r[epcvb_pkg::EV_W-1:0] : '0;
  assign evstat_nxt = ev_in | (evstat_r & ~ev_clr);
  assign evmask_nxt = wr_evmask & wstrb_r[0] ? wdata_r[epcvb_pkg::EV_W-1:0] : evmask_r;

  // highest pending number from the selector
  wire logic [epcvb_pkg::HPN_W-1:0] hpn_nxt;
  epcvb_prio u_prio (
    .periph_pend (periph_pend),
    .nmi_pend    (nmi_r),
    .tick_pend   (tick_r & tick_enable),
    .def_pend    (def_r),
    .number      (hpn_nxt)
  );

  // read decode; clear bits and reserved bits read zero
  wire logic [31:0] rd_state;
  wire logic [31:0] rd_word;
  wire logic        rd_hit;
  assign rd_state = (32'(nmi_r) << epcvb_pkg::BIT_NMI_SET) |
                    (32'(def_r) << epcvb_pkg::BIT_DEF_SET) |
                    (32'(tick_r) << epcvb_pkg::BIT_TICK_SET) |
                    (32'(hpn_r) << epcvb_pkg::HPN_LSB);
  assign rd_hit   = (s_axi_araddr == epcvb_pkg::OFS_STATE) | (s_axi_araddr == epcvb_pkg::OFS_VBASE) |
                    (s_axi_araddr == epcvb_pkg::OFS_EVSTAT) | (s_axi_araddr == epcvb_pkg::OFS_EVMASK);
  assign rd_word  = (s_axi_araddr == epcvb_pkg::OFS_STATE)  ? rd_state :
                    (s_axi_araddr == epcvb_pkg::OFS_VBASE)  ? vbase_r :
                    (s_axi_araddr == epcvb_pkg::OFS_EVSTAT) ? 32'(evstat_r) :
                    (s_axi_araddr == epcvb_pkg::OFS_EVMASK) ? 32'(evmask_r) : 32'h0000_0000;

  // write address and data are taken independently and held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (aw_hs) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else begin
      if (do_wr) aw_held_r <= 1'b0;
      if (b_hs) awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (w_hs) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else begin
      if (do_wr) w_held_r <= 1'b0;
      if (b_hs) wready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= epcvb_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? epcvb_pkg::RESP_OKAY : epcvb_pkg::RESP_SLVERR;
    end else if (b_hs) begin
      bvalid_r <= 1'b0;
    end
  end

  // read answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= epcvb_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_word;
      rresp_r   <= rd_hit ? epcvb_pkg::RESP_OKAY : epcvb_pkg::RESP_SLVERR;
    end else if (r_hs) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // pending state and vector base
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_r      <= 1'b0;
      nmi_line_r <= 1'b0;
      def_r      <= 1'b0;
      tick_r     <= 1'b0;
      hpn_r      <= epcvb_pkg::EXC_NONE;
    end else begin
      nmi_r      <= nmi_nxt;
      nmi_line_r <= nmi_line;
      def_r      <= def_nxt;
      tick_r     <= tick_nxt;
      hpn_r      <= hpn_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbase_r <= epcvb_pkg::VBASE_RESET;
    end else if (wr_vbase) begin
      vbase_r <= vbase_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evstat_r <= '0;
      evmask_r <= '0;
      irq_r    <= 1'b0;
    end else begin
      evstat_r <= evstat_nxt;
      evmask_r <= evmask_nxt;
      irq_r    <= |(evstat_nxt & evmask_nxt);
    end
  end

  // outputs
  assign s_axi_awready          = awready_r;
  assign s_axi_wready           = wready_r;
  assign s_axi_bvalid           = bvalid_r;
  assign s_axi_bresp            = bresp_r;
  assign s_axi_arready          = arready_r;
  assign s_axi_rvalid           = rvalid_r;
  assign s_axi_rdata            = rdata_r;
  assign s_axi_rresp            = rresp_r;
  assign nmi_pending            = nmi_r;
  assign deferred_pending       = def_r;
  assign tick_pending           = tick_r;
  assign highest_pending_number = hpn_r;
  assign vector_base            = vbase_r;
  assign irq                    = irq_r;
endmodule
`default_nettype wire

// [tb/epcvb_chk.sv]
// concurrent checks on the exception pend control and vector base block
// bound to epcvb_top; sees its ports only, one clock domain
`timescale 1ns/10ps
`default_nettype none
module epcvb_chk (
  // clock and reset
  input wire logic                           aclk,
  input wire logic                           aresetn,
  // register bus
  input wire logic                           s_axi_awvalid,
  input wire logic                           s_axi_awready,
  input wire logic [epcvb_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input wire logic                           s_axi_wvalid,
  input wire logic                           s_axi_wready,
  input wire logic [31:0]                    s_axi_wdata,
  input wire logic [3:0]                     s_axi_wstrb,
  input wire logic                           s_axi_bvalid,
  input wire logic [1:0]                     s_axi_bresp,
  input wire logic                           s_axi_arvalid,
  input wire logic                           s_axi_arready,
  input wire logic                           s_axi_rvalid,
  // sources and core side
  input wire logic                           nmi_line,
  input wire logic [epcvb_pkg::N_PERIPH-1:0] periph_pend,
  input wire logic                           exc_entry,
  input wire logic [epcvb_pkg::HPN_W-1:0]    exc_entry_num,
  input wire logic                           nmi_pending,
  input wire logic                           deferred_pending,
  input wire logic                           tick_pending,
  input wire logic [epcvb_pkg::HPN_W-1:0]    highest_pending_number,
  input wire logic [31:0]                    vector_base
);
  logic [7:0]  aw_a_r;
  logic [31:0] w_d_r;
  logic [3:0]  w_s_r;
  logic [3:0]  wr_age_r;
  logic        unmapped_w;
  // last accepted write, so the effect can be tied to its cause
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_a_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) w_d_r <= s_axi_wdata;
    if (s_axi_wvalid && s_axi_wready) w_s_r <= s_axi_wstrb;
    if (!aresetn) wr_age_r <= 4'hF;
    else if ((s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready)) wr_age_r <= 4'h0;
    else if (wr_age_r != 4'hF) wr_age_r <= wr_age_r + 4'h1;
  end
  assign unmapped_w = !(aw_a_r inside {epcvb_pkg::OFS_STATE, epcvb_pkg::OFS_VBASE, epcvb_pkg::OFS_EVSTAT,
                                       epcvb_pkg::OFS_EVMASK});
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_nmi_wr_set: assert property ($rose(s_axi_bvalid) && aw_a_r == epcvb_pkg::OFS_STATE && w_d_r[31] &&
    w_s_r[3] |-> ##[0:2] nmi_pending) else $error("nmi set write lost");
  a_def_wr_clr: assert property ($rose(s_axi_bvalid) && aw_a_r == epcvb_pkg::OFS_STATE && w_d_r[27] &&
    !w_d_r[28] && w_s_r[3] |-> ##[0:2] !deferred_pending) else $error("deferred clear write lost");
  a_def_sw_only: assert property ($rose(deferred_pending) |-> wr_age_r <= 4'h3)
    else $error("deferred pending rose without a write");
  a_nmi_entry_clr: assert property (exc_entry && exc_entry_num == epcvb_pkg::EXC_NMI && !nmi_line &&
    !$past(nmi_line) && (s_axi_awready || s_axi_wready || s_axi_bvalid) |=> !nmi_pending)
    else $error("nmi entry did not clear pending");
  a_hpn_nmi_top: assert property (nmi_pending [*3] |-> highest_pending_number == epcvb_pkg::EXC_NMI)
    else $error("nmi not reported as highest");
  a_hpn_idle_zero: assert property ((!nmi_pending && !deferred_pending && !tick_pending &&
    periph_pend == '0) [*3] |-> highest_pending_number == epcvb_pkg::EXC_NONE)
    else $error("pending number not zero when idle");
  a_hpn_periph_base: assert property ((!nmi_pending && periph_pend[0]) [*3] |->
    highest_pending_number == epcvb_pkg::EXC_PERIPH_BASE) else $error("peripheral zero not numbered 16");
  a_vbase_wr_mask: assert property ($rose(s_axi_bvalid) && aw_a_r == epcvb_pkg::OFS_VBASE &&
    w_s_r == 4'hF |-> ##[0:2] vector_base == (w_d_r & epcvb_pkg::VBASE_MASK)) else $error("vector base wrong");
  a_unmap_slverr: assert property ($rose(s_axi_bvalid) && unmapped_w |-> s_axi_bresp == epcvb_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  a_rd_one_cycle: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_nmi_entry: cover property (exc_entry && exc_entry_num == epcvb_pkg::EXC_NMI);
  c_def_rise: cover property ($rose(deferred_pending));
  c_unmapped: cover property ($rose(s_axi_bvalid) && unmapped_w);
endmodule
bind epcvb_top epcvb_chk epcvb_chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
  .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .nmi_line, .periph_pend, .exc_entry, .exc_entry_num, .nmi_pending,
  .deferred_pending, .tick_pending, .highest_pending_number, .vector_base);
`default_nettype wire

// [tb/epcvb_core_model.sv]
// behavioural core that enters the handler of the reported exception
// assumes hpn lags pending by a cycle; delay is short or long by slow
`timescale 1ns/10ps
`default_nettype none
module epcvb_core_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench controls
  input  wire logic       en,
  input  wire logic       slow,
  // from the block
  input  wire logic [5:0] hpn,
  // handler entry
  output logic            exc_entry,
  output logic [5:0]      exc_entry_num
);
  logic [3:0] cnt_r;
  logic [3:0] dly_w;
  logic       fire_w;
  assign dly_w  = slow ? 4'h9 : 4'h3;
  assign fire_w = en && hpn != 6'h00 && cnt_r == dly_w;
  always_ff @(posedge aclk) begin
    if (!aresetn || !en || hpn == 6'h00 || fire_w) cnt_r <= 4'h0;
    else cnt_r <= cnt_r + 4'h1;
    exc_entry <= aresetn && fire_w;
    // number wanders between entries so a stale value is never trusted
    if (!aresetn) exc_entry_num <= 6'h00;
    else exc_entry_num <= fire_w ? hpn : exc_entry_num ^ 6'h3F;
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for epcvb_top against an integer model
// assumes the package, the top, the checker and the core model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, core_en, core_slow;
  logic        nmi_line, tick_event, tick_enable, exc_entry, nmi_pending, deferred_pending, tick_pending;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, vector_base, periph_pend, vb;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  exc_entry_num, highest_pending_number;
  logic [2:0]  pend, ev, mask;
  int          mismatches, comparisons;

  epcvb_top epcvb_top_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .nmi_line, .tick_event, .tick_enable, .periph_pend, .exc_entry,
    .exc_entry_num, .nmi_pending, .deferred_pending, .tick_pending, .highest_pending_number, .vector_base, .irq);
  epcvb_core_model epcvb_core_model_i (.aclk, .aresetn, .en(core_en), .slow(core_slow),
    .hpn(highest_pending_number), .exc_entry, .exc_entry_num);

  function automatic logic [5:0] exp_hpn();
    if (pend[0])
      return epcvb_pkg::EXC_NMI;
    for (int i = 0; i < 32; i++)
      if (periph_pend[i])
        return 6'(16 + i);
    if (pend[2] && tick_enable)
      return epcvb_pkg::EXC_TICK;
    return pend[1] ? epcvb_pkg::EXC_DEF : epcvb_pkg::EXC_NONE;
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pset(input int i);
    if (!pend[i]) ev[i] = 1'b1;
    pend[i] = 1'b1;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk_resp(s_axi_bresp, er);
    repeat (3) @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk_val(s_axi_rdata & m, e & m);
    chk_resp(s_axi_rresp, er);
    @(posedge aclk);
  endtask
  // clear bits read back as zero, but the mask leaves them out of the compare
  task automatic rd_state();
    axi_rd(epcvb_pkg::OFS_STATE, {pend[0], 2'h0, pend[1], 1'h0, pend[2], 8'h00, exp_hpn(), 12'h000},
           32'hF5FF_FFFF, epcvb_pkg::RESP_OKAY);
    chk_val({31'h0, irq}, {31'h0, |(ev & mask)});
    chk_val({29'h0, nmi_pending, deferred_pending, tick_pending}, {29'h0, pend[0], pend[1], pend[2]});
    chk_val(32'(highest_pending_number), 32'(exp_hpn()));
  endtask
  task automatic wst(input logic [31:0] d);
    axi_wr(epcvb_pkg::OFS_STATE, d, 4'hF, epcvb_pkg::RESP_OKAY);
  endtask
  task automatic nmi_enter(input logic sl);
    core_slow <= sl;
    core_en <= 1'b1;
    for (int n = 0; n < 40 && nmi_pending !== 1'b0; n++) @(posedge aclk);
    core_en <= 1'b0;
    pend[0] = 1'b0;
    repeat (3) @(posedge aclk);
    rd_state();
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [31:0] d;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {nmi_line, tick_event, tick_enable, core_en, core_slow, pend, ev, mask, mismatches, comparisons} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, periph_pend} = '0;
    vb = epcvb_pkg::VBASE_RESET;
    d = $urandom(32'hBBE0);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(epcvb_pkg::OFS_VBASE, vb, 32'hFFFF_FFFF, epcvb_pkg::RESP_OKAY);
    rd_state();
    axi_wr(epcvb_pkg::OFS_EVMASK, 32'h7, 4'hF, epcvb_pkg::RESP_OKAY);
    mask = 3'h7;
    wst(32'h0000_0000);
    rd_state();
    wst(32'h8000_0000);
    pset(0);
    rd_state();
    for (int k = 0; k < 2; k++) begin
      nmi_enter(k[0]);
      nmi_line <= 1'b1;
      repeat (3) @(posedge aclk);
      nmi_line <= 1'b0;
      pset(0);
      rd_state();
    end
    axi_rd(epcvb_pkg::OFS_EVSTAT, {29'h0, ev}, 32'hFFFF_FFFF, epcvb_pkg::RESP_OKAY);
    axi_wr(epcvb_pkg::OFS_EVSTAT, 32'h7, 4'hF, epcvb_pkg::RESP_OKAY);
    ev = 3'h0;
    nmi_enter(1'b0);
    wst(32'h1000_0000);
    pset(1);
    tick_enable <= 1'b1;
    wst(32'h0400_0000);
    pset(2);
    rd_state();
    wst(32'h0800_0000);
    pend[1] = 1'b0;
    wst(32'h0200_0000);
    pend[2] = 1'b0;
    rd_state();
    tick_event <= 1'b1;
    @(posedge aclk);
    tick_event <= 1'b0;
    pset(2);
    repeat (3) @(posedge aclk);
    rd_state();
    wst(32'h1000_0000);
    pset(1);
    tick_enable <= 1'b0;
    // let the gated number settle before the model reads the enable
    repeat (2) @(posedge aclk);
    rd_state();
    wst(32'h0A00_0000);
    pend[2] = 1'b0;
    pend[1] = 1'b0;
    for (int k = 0; k < 4; k++) begin
      wst($urandom & 32'h61FF_FFFF);
      rd_state();
    end
    for (int k = 0; k < 6; k++) begin
      periph_pend <= $urandom >> (k * 5);
      repeat (3) @(posedge aclk);
      rd_state();
    end
    periph_pend <= 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      axi_wr(epcvb_pkg::OFS_VBASE, d, 4'hF, epcvb_pkg::RESP_OKAY);
      vb = d & epcvb_pkg::VBASE_MASK;
      axi_rd(epcvb_pkg::OFS_VBASE, vb, 32'hFFFF_FFFF, epcvb_pkg::RESP_OKAY);
      chk_val(vector_base, vb);
    end
    axi_wr(8'h0C, $urandom, 4'hF, epcvb_pkg::RESP_SLVERR);
    axi_rd(8'h0C, 32'h0, 32'hFFFF_FFFF, epcvb_pkg::RESP_SLVERR);
    axi_wr(epcvb_pkg::OFS_EVMASK, 32'h0, 4'hF, epcvb_pkg::RESP_OKAY);
    mask = 3'h0;
    rd_state();
    report_and_stop();
  end
endmodule
`default_nettype wire
